// ### include/gpb_pkg.sv
package gpb_pkg;

   // =====================================================================
   // Bank shape
   // =====================================================================
   localparam int NUM_PORTS          = 4;
   localparam int PORT_WIDTH         = 16;
   localparam int HOST_DATA_WIDTH    = 16;
   localparam int HOST_ADDR_WIDTH    = 5;
   // Bit position that the last (narrow) port does not implement
   localparam int NARROW_MISSING_BIT = 0;

   // =====================================================================
   // Register map, host byte addresses and register indexes
   // =====================================================================
   localparam logic [23:0] REG_BASE_BYTE    = 24'hC0_0002;
   localparam logic [23:0] PORT_A_VALUE_BYTE = 24'hC0_0002;
   localparam logic [23:0] PORT_A_DIR_BYTE   = 24'hC0_0006;
   localparam logic [23:0] PORT_B_VALUE_BYTE = 24'hC0_000A;
   localparam logic [23:0] PORT_B_DIR_BYTE   = 24'hC0_000E;
   localparam logic [23:0] PORT_C_VALUE_BYTE = 24'hC0_0012;
   localparam logic [23:0] PORT_C_DIR_BYTE   = 24'hC0_0016;
   localparam logic [23:0] PORT_D_VALUE_BYTE = 24'hC0_001A;
   localparam logic [23:0] PORT_D_DIR_BYTE   = 24'hC0_001E;

   // Register index on the five address lines: (byte - base) / 4
   localparam logic [4:0] IDX_PORT_A_VALUE =
      5'((PORT_A_VALUE_BYTE - REG_BASE_BYTE) >> 2);
   localparam logic [4:0] IDX_PORT_A_DIR   =
      5'((PORT_A_DIR_BYTE - REG_BASE_BYTE) >> 2);
   localparam logic [4:0] IDX_PORT_D_VALUE =
      5'((PORT_D_VALUE_BYTE - REG_BASE_BYTE) >> 2);
   localparam logic [4:0] IDX_PORT_D_DIR   =
      5'((PORT_D_DIR_BYTE - REG_BASE_BYTE) >> 2);
   // First index past the implemented registers
   localparam logic [4:0] IDX_END          = 5'h08;

   // =====================================================================
   // Reset values
   // =====================================================================
   localparam logic [15:0] VALUE_RESET   = 16'h0000;
   localparam logic [15:0] DIR_RESET     = 16'h0000;
   localparam logic [15:0] READ_IDLE     = 16'h0000;

   // =====================================================================
   // Host access timing, in host interface cycles
   // =====================================================================
   localparam int HOST_SETUP_CYC      = 2;
   localparam int HOST_STROBE_CYC     = 4;
   localparam int HOST_HOLD_CYC       = 2;
   localparam int HOST_WRITE_CYC      = 11;
   localparam int HOST_READ_HOLD_CYC  = 10;
   localparam int HOST_READ_CYC       = 18;
   // Cycles from strobe active to read data on the bus
   localparam int READ_DRIVE_LAT      = 1;

endpackage : gpb_pkg

// ### rtl/gpb_top.sv
// Operation
// - Four ports: three sixteen bits wide, one fifteen bits wide.
// - Every port has one direction register and one value register.
// - Direction bit 0 makes the pin input, 1 makes it driven output.
// - Value read returns pin levels; value write sets driven output level.
// - After reset all direction bits are clear, no pin driven.
// - Input pins get a weak keeper holding their last level.
// - Register selected by five low host address lines, 32 slots.
// - Access needs region select plus write strobe, or read plus enable.
// - Logic may run from the host clock output, default 150 MHz.
// - Host data lines driven only during a valid read to us.
// - Host address lines are inputs only, never driven.
// - Host strobe and select lines are inputs only, never driven.
// - Host clock pins are inputs only; may clock the logic.
module gpb_top
   import gpb_pkg::*;
#(
   parameter int PORT_W = PORT_WIDTH
)(
   input  wire logic                       MCLK,
   input  wire logic                       RST_N,
   input  wire logic [HOST_ADDR_WIDTH-1:0] HOST_ADDR,
   input  wire logic [HOST_DATA_WIDTH-1:0] HOST_DATA_IN,
   output logic      [HOST_DATA_WIDTH-1:0] HOST_DATA_OUT,
   output logic      [HOST_DATA_WIDTH-1:0] HOST_DATA_OE_N,
   input  wire logic                       HOST_REGION_SELECT_N,
   input  wire logic                       HOST_WRITE_STROBE_N,
   input  wire logic                       HOST_READ_STROBE_N,
   input  wire logic                       HOST_OUTPUT_ENABLE_N,
   input  wire logic [PORT_W-1:0]          PORT_A_IN,
   output logic      [PORT_W-1:0]          PORT_A_OUT,
   output logic      [PORT_W-1:0]          PORT_A_OE_N,
   output logic      [PORT_W-1:0]          PORT_A_KEEP,
   input  wire logic [PORT_W-1:0]          PORT_B_IN,
   output logic      [PORT_W-1:0]          PORT_B_OUT,
   output logic      [PORT_W-1:0]          PORT_B_OE_N,
   output logic      [PORT_W-1:0]          PORT_B_KEEP,
   input  wire logic [PORT_W-1:0]          PORT_C_IN,
   output logic      [PORT_W-1:0]          PORT_C_OUT,
   output logic      [PORT_W-1:0]          PORT_C_OE_N,
   output logic      [PORT_W-1:0]          PORT_C_KEEP,
   input  wire logic [PORT_W-1:0]          PORT_D_IN,
   output logic      [PORT_W-1:0]          PORT_D_OUT,
   output logic      [PORT_W-1:0]          PORT_D_OE_N,
   output logic      [PORT_W-1:0]          PORT_D_KEEP
);

   // =====================================================================
   // Host strobe decode
   // =====================================================================
   // Address, strobes and clock are only ever sampled, never driven
   logic                       wr_act;
   logic                       rd_act;
   logic                       wr_take;
   logic                       wr_act_reg;
   logic [HOST_ADDR_WIDTH-1:0] reg_idx;
   logic                       idx_mapped;
   logic [1:0]                 rd_port;

   assign reg_idx    = HOST_ADDR;
   assign wr_act     = ~HOST_REGION_SELECT_N
                       & ~HOST_WRITE_STROBE_N;
   assign rd_act     = ~HOST_REGION_SELECT_N & ~HOST_READ_STROBE_N
                       & ~HOST_OUTPUT_ENABLE_N;
   // One register write per strobe, taken on its first active cycle
   assign wr_take    = wr_act & ~wr_act_reg;
   assign idx_mapped = reg_idx < IDX_END;
   assign rd_port    = reg_idx[2:1];

   // MCLK may be the host clock output itself
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         wr_act_reg <= 1'b0;
      end else begin
         wr_act_reg <= wr_act;
      end
   end

   // =====================================================================
   // Port registers
   // =====================================================================
   logic [PORT_W-1:0] pin_in    [NUM_PORTS];
   logic [PORT_W-1:0] value_reg [NUM_PORTS];
   logic [PORT_W-1:0] oe_n_reg  [NUM_PORTS];
   logic [PORT_W-1:0] port_mask [NUM_PORTS];
   logic [PORT_W-1:0] wr_data;

   assign pin_in[0] = PORT_A_IN;
   assign pin_in[1] = PORT_B_IN;
   assign pin_in[2] = PORT_C_IN;
   assign pin_in[3] = PORT_D_IN;
   assign wr_data   = PORT_W'(HOST_DATA_IN);

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic              wr_value;
      logic              wr_dir;
      logic [PORT_W-1:0] value_next;
      logic [PORT_W-1:0] oe_n_next;

      // Last port is the narrow one with its low bit missing
      assign port_mask[p] = (p == NUM_PORTS - 1)
         ? ~(PORT_W'(1) << NARROW_MISSING_BIT) : '1;
      assign wr_value   = wr_take
         && reg_idx == 5'(IDX_PORT_A_VALUE + 5'(2 * p));
      assign wr_dir     = wr_take
         && reg_idx == 5'(IDX_PORT_A_DIR + 5'(2 * p));
      // Latch updates whatever the direction
      assign value_next = wr_value ? (wr_data & port_mask[p])
                                   : value_reg[p];
      // Stored inverted so the enable leaves a flop directly
      assign oe_n_next  = wr_dir ? ~(wr_data & port_mask[p])
                                 : oe_n_reg[p];

      always_ff @(posedge MCLK) begin
         if (!RST_N) begin
            value_reg[p] <= PORT_W'(VALUE_RESET);
            oe_n_reg[p]  <= ~PORT_W'(DIR_RESET);
         end else begin
            value_reg[p] <= value_next;
            oe_n_reg[p]  <= oe_n_next;
         end
      end
   end

   assign PORT_A_OUT  = value_reg[0];
   assign PORT_B_OUT  = value_reg[1];
   assign PORT_C_OUT  = value_reg[2];
   assign PORT_D_OUT  = value_reg[3];
   assign PORT_A_OE_N = oe_n_reg[0];
   assign PORT_B_OE_N = oe_n_reg[1];
   assign PORT_C_OE_N = oe_n_reg[2];
   assign PORT_D_OE_N = oe_n_reg[3];
   // Keeper on exactly the pins that are inputs
   assign PORT_A_KEEP = oe_n_reg[0];
   assign PORT_B_KEEP = oe_n_reg[1];
   assign PORT_C_KEEP = oe_n_reg[2];
   assign PORT_D_KEEP = oe_n_reg[3];

   // =====================================================================
   // Read path
   // =====================================================================
   logic [PORT_W-1:0]          rd_word;
   logic [HOST_DATA_WIDTH-1:0] data_out_reg;
   logic [HOST_DATA_WIDTH-1:0] data_out_next;
   logic [HOST_DATA_WIDTH-1:0] data_oe_n_reg;

   // Value reads show live pin levels; reads have no side effect
   assign rd_word = !idx_mapped ? '0
      : reg_idx[0] ? (~oe_n_reg[rd_port] & port_mask[rd_port])
      : (pin_in[rd_port] & port_mask[rd_port]);
   assign data_out_next = rd_act ? HOST_DATA_WIDTH'(rd_word)
                                 : data_out_reg;

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         data_out_reg  <= READ_IDLE;
         data_oe_n_reg <= '1;
      end else begin
         data_out_reg  <= data_out_next;
         data_oe_n_reg <= {HOST_DATA_WIDTH{~rd_act}};
      end
   end

   assign HOST_DATA_OUT  = data_out_reg;
   assign HOST_DATA_OE_N = data_oe_n_reg;

   // =====================================================================
   // Checks
   // =====================================================================
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   chk_reset_all_inputs:
   assert property ($rose(RST_N) |->
      (&PORT_A_OE_N) && (&PORT_B_OE_N) && (&PORT_C_OE_N) && (&PORT_D_OE_N))
      else $error("pins not all inputs after reset");

   chk_narrow_bit_absent:
   assert property (PORT_D_OE_N[NARROW_MISSING_BIT]
      && !PORT_D_OUT[NARROW_MISSING_BIT])
      else $error("narrow port missing bit is active");

   chk_dir_write_effect:
   assert property (wr_take && reg_idx == IDX_PORT_A_DIR |=>
      PORT_A_OE_N == ~$past(wr_data))
      else $error("direction write did not set enables");

   chk_value_latch_write:
   assert property (wr_take && reg_idx == IDX_PORT_D_VALUE |=>
      PORT_D_OUT == ($past(wr_data) & port_mask[3]))
      else $error("value write did not reach latch");

   chk_bus_released:
   assert property (!rd_act |=> &HOST_DATA_OE_N)
      else $error("host data driven outside a read");

   chk_read_pin_level:
   assert property (rd_act && reg_idx == IDX_PORT_A_VALUE |=>
      !HOST_DATA_OE_N[0] && HOST_DATA_OUT == $past(PORT_A_IN))
      else $error("value read did not return pin level");

   chk_keeper_on_inputs:
   assert property (PORT_B_KEEP == PORT_B_OE_N && PORT_C_KEEP == PORT_C_OE_N)
      else $error("keeper does not follow input pins");

   chk_unselected_write:
   assert property (HOST_REGION_SELECT_N |=>
      $stable(value_reg[0]) && $stable(oe_n_reg[0]))
      else $error("register changed without region select");

   chk_unmapped_read:
   assert property (rd_act && !idx_mapped |=> HOST_DATA_OUT == '0)
      else $error("unmapped read returned nonzero");

   chk_dir_readback:
   assert property (rd_act && reg_idx == IDX_PORT_D_DIR |=>
      HOST_DATA_OUT == HOST_DATA_WIDTH'(~$past(PORT_D_OE_N)))
      else $error("direction read does not match enables");

   chk_read_needs_strobes:
   assert property (HOST_REGION_SELECT_N || HOST_READ_STROBE_N
      || HOST_OUTPUT_ENABLE_N |=> &HOST_DATA_OE_N)
      else $error("host data driven without all read strobes");

   chk_write_once_strobe:
   assert property (wr_act && wr_act_reg |=>
      $stable(value_reg[1]) && $stable(oe_n_reg[1]))
      else $error("held write strobe wrote again");

   chk_dir_write_b:
   assert property (wr_take && reg_idx == IDX_PORT_A_DIR + 5'h02 |=>
      PORT_B_OE_N == ~$past(wr_data))
      else $error("port B direction write did not set enables");

   chk_dir_write_c:
   assert property (wr_take && reg_idx == IDX_PORT_A_DIR + 5'h04 |=>
      PORT_C_OE_N == ~$past(wr_data))
      else $error("port C direction write did not set enables");

   chk_value_write_a:
   assert property (wr_take && reg_idx == IDX_PORT_A_VALUE |=>
      PORT_A_OUT == $past(wr_data))
      else $error("port A value write did not reach latch");

   chk_value_write_c:
   assert property (wr_take && reg_idx == IDX_PORT_A_VALUE + 5'h04 |=>
      PORT_C_OUT == $past(wr_data))
      else $error("port C value write did not reach latch");

   chk_narrow_read_zero:
   assert property (rd_act && reg_idx == IDX_PORT_D_VALUE |=>
      !HOST_DATA_OUT[NARROW_MISSING_BIT])
      else $error("narrow port missing bit read as one");

   chk_read_pin_b:
   assert property (rd_act && reg_idx == IDX_PORT_A_VALUE + 5'h02 |=>
      HOST_DATA_OUT == $past(PORT_B_IN))
      else $error("port B value read did not return pin level");

   chk_read_pin_c:
   assert property (rd_act && reg_idx == IDX_PORT_A_VALUE + 5'h04 |=>
      HOST_DATA_OUT == $past(PORT_C_IN))
      else $error("port C value read did not return pin level");

   chk_pins_need_write:
   assert property (!wr_take |=>
      $stable(PORT_A_OUT) && $stable(PORT_A_OE_N) && $stable(PORT_D_OE_N))
      else $error("pin outputs changed without a write");

   chk_read_drives_all:
   assert property (rd_act |=> HOST_DATA_OE_N == '0)
      else $error("host data not driven during a read");

   chk_keeper_a_d:
   assert property (PORT_A_KEEP == PORT_A_OE_N && PORT_D_KEEP == PORT_D_OE_N)
      else $error("keeper does not follow input pins");

   chk_data_out_holds:
   assert property (!rd_act |=> $stable(HOST_DATA_OUT))
      else $error("read data changed outside a read");

   chk_unmapped_write_ignored:
   assert property (wr_take && !idx_mapped |=>
      $stable(value_reg[0]) && $stable(oe_n_reg[3]))
      else $error("unmapped write changed a register");

   chk_reset_clears_outputs:
   assert property ($rose(RST_N) |->
      PORT_A_OUT == PORT_W'(VALUE_RESET) && PORT_D_OUT == PORT_W'(VALUE_RESET)
      && &HOST_DATA_OE_N)
      else $error("outputs not cleared by reset");

   chk_dir_readback_a:
   assert property (rd_act && reg_idx == IDX_PORT_A_DIR |=>
      HOST_DATA_OUT == HOST_DATA_WIDTH'(~$past(PORT_A_OE_N)))
      else $error("port A direction read does not match enables");

   chk_quiet_during_write:
   assert property (wr_act && HOST_READ_STROBE_N |=> &HOST_DATA_OE_N)
      else $error("host data driven during a write");

endmodule : gpb_top

// ### dv/gpb_host_model.sv
// =========================================================
// Host external memory port, asynchronous cycles
// =========================================================
module gpb_host_model
   import gpb_pkg::*;
(
   input  wire logic                       mclk,
   input  wire logic [HOST_DATA_WIDTH-1:0] bus,
   input  wire logic [HOST_DATA_WIDTH-1:0] dev_oe_n,
   output logic      [HOST_ADDR_WIDTH-1:0] addr,
   output logic      [HOST_DATA_WIDTH-1:0] drv,
   output logic                            sel_n,
   output logic                            wr_n,
   output logic                            rd_n,
   output logic                            oe_n
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      addr  = 5'h00;
      drv   = 16'h0000;
      sel_n = 1'b1;
      wr_n  = 1'b1;
      rd_n  = 1'b1;
      oe_n  = 1'b1;
   end

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask : idle

   // Setup, strobe, hold, padded to the full write length
   task automatic wr(input logic [4:0] idx, input logic [15:0] d,
                     input logic en);
      @(negedge mclk);
      addr  = idx;
      drv   = d;
      sel_n = ~en;
      idle(HOST_SETUP_CYC);
      wr_n = 1'b0;
      idle(HOST_STROBE_CYC);
      wr_n = 1'b1;
      idle(HOST_HOLD_CYC);
      sel_n = 1'b1;
      // Released bus shows the inverse of the last value
      drv = ~d;
      idle(HOST_WRITE_CYC - HOST_SETUP_CYC - HOST_STROBE_CYC
           - HOST_HOLD_CYC - 1);
   endtask : wr

   // A single read cycle with its long hold period
   // Data is taken on the last strobe cycle, where the device output settled
   task automatic rd(input logic [4:0] idx, output logic [15:0] q,
                     output logic driven, input logic en = 1'b1);
      @(negedge mclk);
      addr  = idx;
      sel_n = 1'b0;
      idle(HOST_SETUP_CYC);
      rd_n = 1'b0;
      oe_n = ~en;
      idle(HOST_STROBE_CYC);
      q      = bus;
      driven = (dev_oe_n === 16'h0000);
      rd_n = 1'b1;
      oe_n = 1'b1;
      idle(HOST_HOLD_CYC);
      sel_n = 1'b1;
      idle(HOST_READ_HOLD_CYC - 1);
   endtask : rd
endmodule : gpb_host_model

// ### dv/tb_four_port_gpio_bank.sv
module tb_four_port_gpio_bank
   import gpb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk, rst_n, sel_n, wr_n, rd_n, oe_n, on;
   logic [4:0]  addr;
   logic [15:0] drv, dout, doe_n, bus, q, m;
   logic [15:0] p_in[4], p_out[4], p_oe[4], p_keep[4];
   int          n_fail, samples_checked;

   assign bus = (~doe_n & dout) | (doe_n & drv);

   gpb_top DUT (.MCLK(mclk), .RST_N(rst_n), .HOST_ADDR(addr),
      .HOST_DATA_IN(bus), .HOST_DATA_OUT(dout), .HOST_DATA_OE_N(doe_n),
      .HOST_REGION_SELECT_N(sel_n), .HOST_WRITE_STROBE_N(wr_n),
      .HOST_READ_STROBE_N(rd_n), .HOST_OUTPUT_ENABLE_N(oe_n),
      .PORT_A_IN(p_in[0]), .PORT_A_OUT(p_out[0]), .PORT_A_OE_N(p_oe[0]),
      .PORT_A_KEEP(p_keep[0]), .PORT_B_IN(p_in[1]), .PORT_B_OUT(p_out[1]),
      .PORT_B_OE_N(p_oe[1]), .PORT_B_KEEP(p_keep[1]), .PORT_C_IN(p_in[2]),
      .PORT_C_OUT(p_out[2]), .PORT_C_OE_N(p_oe[2]), .PORT_C_KEEP(p_keep[2]),
      .PORT_D_IN(p_in[3]), .PORT_D_OUT(p_out[3]), .PORT_D_OE_N(p_oe[3]),
      .PORT_D_KEEP(p_keep[3]));

   gpb_host_model host (.mclk(mclk), .bus(bus), .dev_oe_n(doe_n),
      .addr(addr), .drv(drv), .sel_n(sel_n), .wr_n(wr_n), .rd_n(rd_n),
      .oe_n(oe_n));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   // =========================================================
   // Clock, watchdog and test sequence
   // =========================================================
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   initial begin
      repeat (5000) @(posedge mclk);
      n_fail++;
      close_out();
   end

   initial begin
      rst_n = 1'b0;
      for (int i = 0; i < NUM_PORTS; i++) p_in[i] = 16'hC3A5 ^ 16'(i << 4);
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      chk(doe_n, 16'hFFFF);
      for (int i = 0; i < NUM_PORTS; i++) begin
         chk(p_oe[i], 16'hFFFF);
         chk(p_keep[i], 16'hFFFF);
         chk(p_out[i], VALUE_RESET);
         host.rd(5'(2 * i + 1), q, on);
         chk(q, DIR_RESET);
      end
      for (int i = 0; i < NUM_PORTS; i++) begin
         m = (i == 3) ? 16'hFFFE : 16'hFFFF;
         host.wr(5'(2 * i), 16'h5A0F ^ 16'(i), 1'b1);
         chk(p_out[i], (16'h5A0F ^ 16'(i)) & m);
         chk(p_oe[i], 16'hFFFF);
         host.wr(5'(2 * i + 1), 16'h00FF, 1'b1);
         chk(p_oe[i], ~(16'h00FF & m));
         chk(p_keep[i], ~(16'h00FF & m));
         host.rd(5'(2 * i + 1), q, on);
         chk(q, 16'h00FF & m);
         chk({15'h0000, on}, 16'h0001);
         host.rd(5'(2 * i), q, on);
         chk(q, p_in[i] & m);
         chk(doe_n, 16'hFFFF);
      end
      p_in[1] = 16'h1234;
      host.rd(IDX_PORT_A_VALUE + 5'h02, q, on);
      chk(q, 16'h1234);
      host.wr(IDX_PORT_A_VALUE, 16'hFFFF, 1'b0);
      chk(p_out[0], 16'h5A0F);
      host.wr(IDX_END, 16'hFFFF, 1'b1);
      host.wr(5'h1F, 16'hFFFF, 1'b1);
      host.rd(5'h1F, q, on);
      chk(q, READ_IDLE);
      for (int i = 0; i < NUM_PORTS; i++) begin
         m = (i == 3) ? 16'hFFFE : 16'hFFFF;
         chk(p_out[i], (16'h5A0F ^ 16'(i)) & m);
         chk(p_oe[i], ~(16'h00FF & m));
      end
      host.wr(IDX_PORT_A_DIR, 16'h0000, 1'b1);
      chk(p_oe[0], 16'hFFFF);
      chk(p_out[0], 16'h5A0F);
      host.rd(IDX_PORT_A_VALUE, q, on, 1'b0);
      chk({15'h0000, on}, 16'h0000);
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      for (int i = 0; i < NUM_PORTS; i++) begin
         chk(p_oe[i], 16'hFFFF);
         chk(p_out[i], VALUE_RESET);
      end
      host.rd(IDX_PORT_D_DIR, q, on);
      chk(q, DIR_RESET);
      close_out();
   end
endmodule : tb_four_port_gpio_bank
